// >>> logic/dls_fifo.sv
// Purpose: Word FIFO between capture and serializer
// Assumes: Single clock, valid/ready on both sides
// Notes: Depth must be a power of two

`timescale 1ns/10ps

module dls_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 16
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_clear,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } dls_fifo_st_t;

    dls_fifo_st_t st_reg;
    dls_fifo_st_t st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;
    logic full;
    logic empty;

    assign full = (st_reg.wr[AW] != st_reg.rd[AW]) && (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
    assign empty = (st_reg.wr == st_reg.rd);
    assign o_in_ready = !full && !i_clear;
    assign o_out_valid = !empty && !i_clear;
    assign o_out_data = mem[st_reg.rd[AW-1:0]];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        st_next = st_reg;
        if (i_clear) begin
            st_next = '0;
        end else begin
            if (push) begin
                st_next.wr = st_reg.wr + 1'b1;
            end
            if (pop) begin
                st_next.rd = st_reg.rd + 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage carries no reset; only pointers decide what is visible
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[st_reg.wr[AW-1:0]] <= i_in_data;
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        full && !pop && !i_clear |=> full)
        else $error("FIFO lost full state without a pop");

endmodule : dls_fifo

// >>> logic/dls_pkg.sv
// Purpose: Shared constants and types for the 28-to-4 display link serializer
// Assumes: One core clock at 40 MHz; pixel clock arrives as a sampled pin
// Notes: Slot map gives the parallel bit index per lane and serial slot

package dls_pkg;

    localparam int CORE_CLK_HZ = 40_000_000;
    localparam int CORE_PERIOD_PS = 25_000;
    localparam int WORD_W = 28;
    localparam int LANES = 4;
    localparam int SLOTS = 7;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_HIGH_SLOTS = 4;

    // Lock delay after shutdown release, in microseconds
    localparam int LOCK_TIME_US = 10;
    localparam int LOCK_CYCLES = (LOCK_TIME_US * CORE_CLK_HZ) / 1_000_000;

    // Shutdown to float time, in picoseconds; longest time rounds down, at least one cycle
    localparam int DIS_TIME_PS = 12_000;
    localparam int DIS_CYCLES_RAW = DIS_TIME_PS / CORE_PERIOD_PS;
    localparam int DIS_CYCLES = (DIS_CYCLES_RAW < 1) ? 1 : DIS_CYCLES_RAW;

    localparam logic [15:0] LOCK_CNT_RST = 16'h0000;
    localparam logic [2:0] SLOT_RST = 3'h0;

    // Parallel bit index for each slot (outer) and lane (inner)
    typedef logic [4:0] dls_idx_t;
    localparam dls_idx_t SLOT_MAP [SLOTS][LANES] = '{
        '{5'h01, 5'h09, 5'h14, 5'h05},
        '{5'h00, 5'h08, 5'h13, 5'h1B},
        '{5'h07, 5'h12, 5'h1A, 5'h17},
        '{5'h06, 5'h0F, 5'h19, 5'h11},
        '{5'h04, 5'h0E, 5'h18, 5'h10},
        '{5'h03, 5'h0D, 5'h16, 5'h0B},
        '{5'h02, 5'h0C, 5'h15, 5'h0A}
    };

    typedef struct packed {
        logic [3:0] lane;
        logic link_clk;
    } dls_ser_t;

    typedef struct packed {
        logic [3:0] lane_oe_n;
        logic link_clk_oe_n;
    } dls_oe_t;

endpackage : dls_pkg

// >>> logic/dls_serializer.sv
// Purpose: 28-to-4 display link serializer with forwarded link clock
// Assumes: Pixel clock slower than core clock / 14; sampled through two flops
// Notes: Slot timing is paced by a core-clock enable, not by a true 7x PLL
//
// How it works
// - Slot 0 carries bits 1,9,20,5
// - Slot 1 carries bits 0,8,19,27
// - Slot 2 carries bits 7,18,26,23
// - Slot 3 carries bits 6,15,25,17
// - Slot 4 carries bits 4,14,24,16
// - Slot 5 carries bits 3,13,22,11
// - Slot 6 carries bits 2,12,21,10
// - Slot zero aligned with link clock rise
// - Link clock at pixel rate, high four sevenths
// - Lanes valid about 10 us after release
// - Shutdown floats link clock quickly
// - Edge select chooses capture edge
// - High selects rising, low selects falling
// - Shutdown holds all registers but the synchronisers and buffer storage cleared
// - Lanes shift at seven times word rate

`timescale 1ns/10ps

module dls_serializer #(
    parameter int LOCK_CYCLES = dls_pkg::LOCK_CYCLES,
    parameter int WIDTH = dls_pkg::WORD_W,
    parameter int DEPTH = dls_pkg::FIFO_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_pixel_clock_in,
    input wire logic i_capture_edge_select,
    input wire logic i_shutdown_n,
    input wire logic [WIDTH-1:0] i_parallel_input_bits,
    output logic [3:0] o_serial_lane,
    output logic [3:0] o_serial_lane_oe_n,
    output logic o_link_clock_out,
    output logic o_link_clock_out_oe_n,
    output logic o_lanes_valid,
    output logic o_overflow
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    typedef struct packed {
        logic [1:0] clk_s;
        logic [1:0] sel_s;
        logic [1:0] sd_s;
        logic [WIDTH-1:0] d_s1;
        logic [WIDTH-1:0] d_s2;
        logic clk_prev;
        logic [15:0] lock_cnt;
        logic locked;
        logic [7:0] period_cnt;
        logic [7:0] period_len;
        logic [7:0] slot_cnt;
        logic [2:0] slot;
        logic [WIDTH-1:0] word;
        logic have_word;
        logic [3:0] lane;
        logic link_clk;
        logic ovf;
    } dls_st_t;

    dls_st_t st_reg;
    dls_st_t st_next;

    logic sd_n;
    logic clk_rise;
    logic clk_fall;
    logic cap_edge;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [WIDTH-1:0] fifo_out_data;
    logic [3:0] slice_bits;
    logic slot_step;
    logic [7:0] slot_len;

    assign sd_n = st_reg.sd_s[1];
    assign clk_rise = st_reg.clk_s[1] && !st_reg.clk_prev;
    assign clk_fall = !st_reg.clk_s[1] && st_reg.clk_prev;
    // Rising edge when select is high, falling when low
    assign cap_edge = st_reg.sel_s[1] ? clk_rise : clk_fall;

    // Slot length is one seventh of the measured pixel period
    assign slot_len = 8'(st_reg.period_len / 8'(dls_pkg::SLOTS));
    assign slot_step = (st_reg.slot_cnt + 8'h01 >= slot_len);

    ////////////////////////////////////////////////////////////////////////////
    // Word buffer: back-pressure shows as overflow since the pin source cannot stall

    dls_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_clear(!sd_n),
        .i_in_valid(cap_edge && sd_n),
        .o_in_ready(fifo_in_ready),
        .i_in_data(st_reg.d_s2),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out_data)
    );

    // A new word is drawn at the start of each pixel period
    assign fifo_pop = sd_n && (st_reg.slot == 3'h6) && slot_step;

    dls_slicer #(
        .WIDTH(WIDTH),
        .LANES(dls_pkg::LANES)
    ) u_slicer (
        .i_word(st_reg.word),
        .i_slot(st_reg.slot),
        .o_bits(slice_bits)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next = st_reg;
        st_next.clk_s = {st_reg.clk_s[0], i_pixel_clock_in};
        st_next.sel_s = {st_reg.sel_s[0], i_capture_edge_select};
        st_next.sd_s = {st_reg.sd_s[0], i_shutdown_n};
        st_next.d_s1 = i_parallel_input_bits;
        st_next.d_s2 = st_reg.d_s1;
        st_next.clk_prev = st_reg.clk_s[1];
        if (!sd_n) begin
            // Everything but the synchronisers is held at zero
            st_next.clk_prev = 1'b0;
            st_next.lock_cnt = dls_pkg::LOCK_CNT_RST;
            st_next.locked = 1'b0;
            st_next.period_cnt = '0;
            st_next.period_len = '0;
            st_next.slot_cnt = '0;
            st_next.slot = dls_pkg::SLOT_RST;
            st_next.word = '0;
            st_next.have_word = 1'b0;
            st_next.lane = '0;
            st_next.link_clk = 1'b0;
            st_next.ovf = 1'b0;
        end else begin
            // Lock delay counter gates lane validity
            if (!st_reg.locked) begin
                st_next.lock_cnt = st_reg.lock_cnt + 16'h0001;
                if (st_reg.lock_cnt + 16'h0001 >= 16'(LOCK_CYCLES)) begin
                    st_next.locked = 1'b1;
                end
            end
            // Measure pixel period between rising edges
            if (clk_rise) begin
                st_next.period_cnt = '0;
                st_next.period_len = st_reg.period_cnt + 8'h01;
            end else if (st_reg.period_cnt != 8'hFF) begin
                st_next.period_cnt = st_reg.period_cnt + 8'h01;
            end
            if (cap_edge && !fifo_in_ready) begin
                st_next.ovf = 1'b1;
            end
            // Slot sequencer
            if (slot_step) begin
                st_next.slot_cnt = '0;
                if (st_reg.slot == 3'h6) begin
                    st_next.slot = 3'h0;
                    st_next.word = fifo_out_valid ? fifo_out_data : '0;
                    st_next.have_word = fifo_out_valid;
                end else begin
                    st_next.slot = st_reg.slot + 3'h1;
                end
            end else begin
                st_next.slot_cnt = st_reg.slot_cnt + 8'h01;
            end
            // Lane bits and link clock follow the slot, slot zero at clock rise
            st_next.lane = (st_reg.locked && st_reg.have_word) ? slice_bits : 4'h0;
            st_next.link_clk = (st_reg.slot < 3'(dls_pkg::CLK_HIGH_SLOTS));
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs: enables follow the synchronised shutdown level

    assign o_serial_lane = st_reg.lane;
    assign o_link_clock_out = st_reg.link_clk;
    assign o_link_clock_out_oe_n = !sd_n;
    assign o_serial_lane_oe_n = {4{!sd_n}};
    assign o_lanes_valid = st_reg.locked;
    assign o_overflow = st_reg.ovf;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_slot6_step;
        sd_n && (st_reg.slot == 3'h6) && slot_step;
    endsequence

    sequence s_slot0_start;
        st_reg.slot == 3'h0;
    endsequence

    AST_SLOT_WRAP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        s_slot6_step |=> s_slot0_start)
        else $error("Slot did not wrap to zero");

    AST_CLK_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && $past(sd_n) && (st_reg.slot == 3'h2) |=> o_link_clock_out)
        else $error("Link clock low in a high slot");

    AST_CLK_LOW: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && $past(sd_n) && (st_reg.slot == 3'h5) |=> !o_link_clock_out)
        else $error("Link clock high in a low slot");

    AST_FLOAT: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !st_reg.sd_s[0] ##1 1'b1 |-> ##[0:1] o_link_clock_out_oe_n)
        else $error("Link clock not floated after shutdown");

    AST_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !sd_n |=> (st_reg.lock_cnt == '0) && !st_reg.locked && (st_reg.word == '0))
        else $error("State not cleared in shutdown");

    AST_LANE_GATE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !st_reg.locked |=> (o_serial_lane == 4'h0))
        else $error("Lane data before lock");

    AST_EDGE_SEL: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        st_reg.sel_s[1] && clk_fall |-> !cap_edge)
        else $error("Falling edge captured with rising select");

    AST_SLOT0_MAP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && st_reg.locked && st_reg.have_word && (st_reg.slot == 3'h0) |=>
        (o_serial_lane == {$past(st_reg.word[5]), $past(st_reg.word[20]),
        $past(st_reg.word[9]), $past(st_reg.word[1])}))
        else $error("Slot zero lane bits wrong");

    AST_SLOT1_MAP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && st_reg.locked && st_reg.have_word && (st_reg.slot == 3'h1) |=>
        (o_serial_lane == {$past(st_reg.word[27]), $past(st_reg.word[19]),
        $past(st_reg.word[8]), $past(st_reg.word[0])}))
        else $error("Slot one lane bits wrong");

    AST_SLOT2_MAP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && st_reg.locked && st_reg.have_word && (st_reg.slot == 3'h2) |=>
        (o_serial_lane == {$past(st_reg.word[23]), $past(st_reg.word[26]),
        $past(st_reg.word[18]), $past(st_reg.word[7])}))
        else $error("Slot two lane bits wrong");

    AST_SLOT3_MAP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && st_reg.locked && st_reg.have_word && (st_reg.slot == 3'h3) |=>
        (o_serial_lane == {$past(st_reg.word[17]), $past(st_reg.word[25]),
        $past(st_reg.word[15]), $past(st_reg.word[6])}))
        else $error("Slot three lane bits wrong");

    AST_SLOT4_MAP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && st_reg.locked && st_reg.have_word && (st_reg.slot == 3'h4) |=>
        (o_serial_lane == {$past(st_reg.word[16]), $past(st_reg.word[24]),
        $past(st_reg.word[14]), $past(st_reg.word[4])}))
        else $error("Slot four lane bits wrong");

    AST_SLOT5_MAP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && st_reg.locked && st_reg.have_word && (st_reg.slot == 3'h5) |=>
        (o_serial_lane == {$past(st_reg.word[11]), $past(st_reg.word[22]),
        $past(st_reg.word[13]), $past(st_reg.word[3])}))
        else $error("Slot five lane bits wrong");

    AST_SLOT6_MAP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && st_reg.locked && st_reg.have_word && (st_reg.slot == 3'h6) |=>
        (o_serial_lane == {$past(st_reg.word[10]), $past(st_reg.word[21]),
        $past(st_reg.word[12]), $past(st_reg.word[2])}))
        else $error("Slot six lane bits wrong");

    AST_CLK_RISE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        s_slot6_step ##1 sd_n |=> $rose(o_link_clock_out))
        else $error("Link clock did not rise with slot zero");

    AST_CLK_UP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && (st_reg.slot == 3'h0) |=> o_link_clock_out)
        else $error("Link clock low in slot zero");

    AST_CLK_DROP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && (st_reg.slot == 3'h4) |=> !o_link_clock_out)
        else $error("Link clock high in slot four");

    AST_PERIOD: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && clk_rise |=> (st_reg.period_len == $past(st_reg.period_cnt) + 8'h01))
        else $error("Pixel period not measured");

    AST_LOCK_TIME: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(o_lanes_valid) |-> (st_reg.lock_cnt >= 16'(LOCK_CYCLES)))
        else $error("Lanes valid before lock delay");

    AST_OE_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n |-> !o_link_clock_out_oe_n && (o_serial_lane_oe_n == 4'h0))
        else $error("Outputs floated while running");

    AST_OVF_SET: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && cap_edge && !fifo_in_ready |=> o_overflow)
        else $error("Dropped capture not flagged");

    AST_EDGE_RISE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        st_reg.sel_s[1] && clk_rise |-> cap_edge)
        else $error("Rising edge not captured with high select");

    AST_EDGE_FALL: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !st_reg.sel_s[1] && clk_fall |-> cap_edge)
        else $error("Falling edge not captured with low select");

    AST_SHUT_QUIET: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !sd_n |=> (o_serial_lane == 4'h0) && !o_link_clock_out && !o_overflow)
        else $error("Outputs not cleared in shutdown");

    AST_FIFO_CLEARED: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !sd_n |=> !fifo_out_valid)
        else $error("Buffer kept words through shutdown");

    AST_SLOT_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && !slot_step |=> $stable(st_reg.slot))
        else $error("Slot moved without a step");

    AST_SLOT_RANGE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        st_reg.slot != 3'h7)
        else $error("Slot index out of range");

    AST_WORD_LOAD: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        s_slot6_step && fifo_out_valid |=> st_reg.have_word)
        else $error("Buffered word not loaded at slot wrap");

    AST_LANE_IDLE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        sd_n && !st_reg.have_word |=> (o_serial_lane == 4'h0))
        else $error("Lane data without a word");

endmodule : dls_serializer

// >>> logic/dls_slicer.sv
// Purpose: Pick one bit per lane for the given slot from a captured word
// Assumes: Slot index in range 0 to 6
// Notes: Pure lookup, registered by the caller

`timescale 1ns/10ps

module dls_slicer #(
    parameter int WIDTH = 28,
    parameter int LANES = 4
) (
    input wire logic [WIDTH-1:0] i_word,
    input wire logic [2:0] i_slot,
    output logic [LANES-1:0] o_bits
);

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        always_comb begin
            o_bits[g] = 1'b0;
            if (i_slot < 3'(dls_pkg::SLOTS)) begin
                o_bits[g] = i_word[dls_pkg::SLOT_MAP[i_slot][g]];
            end
        end
    end

endmodule : dls_slicer

// >>> tb/dls_serializer_tb_top.sv
// Purpose: Self-checking bench for the display link serializer
// Assumes: 350 ns pixel period, slot length two core cycles
// Notes: Frames rebuilt into words and matched in order against sent words

`timescale 1ns/10ps

`define DLS_CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end

module dls_serializer_tb_top;
    localparam int LOCK_SIM = 64;
    localparam int MAP [7][4] = '{'{1, 9, 20, 5}, '{0, 8, 19, 27}, '{7, 18, 26, 23},
        '{6, 15, 25, 17}, '{4, 14, 24, 16}, '{3, 13, 22, 11}, '{2, 12, 21, 10}};
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_shutdown_n = 1'b1;
    logic i_capture_edge_select = 1'b1;
    logic pix_clk, sent;
    logic [27:0] pix_data, sent_word;
    logic [3:0] o_serial_lane, o_serial_lane_oe_n;
    logic o_link_clock_out, o_link_clock_out_oe_n, o_lanes_valid, o_overflow;
    logic [27:0] sent_q [$];
    logic mon_on = 1'b0;
    logic lprev = 1'b0;
    int err_count = 0;
    int n_checks = 0;
    int n_frames = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    dls_src_model src_u (.i_core_clk(i_core_clk), .i_edge_sel(i_capture_edge_select),
        .o_pixel_clock(pix_clk), .o_data(pix_data), .o_sent(sent), .o_sent_word(sent_word));

    dls_serializer #(.LOCK_CYCLES(LOCK_SIM)) dut_u (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_pixel_clock_in(pix_clk),
        .i_capture_edge_select(i_capture_edge_select), .i_shutdown_n(i_shutdown_n),
        .i_parallel_input_bits(pix_data), .o_serial_lane(o_serial_lane),
        .o_serial_lane_oe_n(o_serial_lane_oe_n), .o_link_clock_out(o_link_clock_out),
        .o_link_clock_out_oe_n(o_link_clock_out_oe_n), .o_lanes_valid(o_lanes_valid),
        .o_overflow(o_overflow));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // Starts at a link clock rise; ends on the cycle of the next one
    task automatic check_frame;
        logic [27:0] w;
        logic [3:0] first;
        logic found;
        int k, g;
        w = 28'h0000000;
        found = 1'b0;
        for (k = 0; k < 7; k++) begin
            first = o_serial_lane;
            for (g = 0; g < 4; g++) w[MAP[k][g]] = first[g];
            `DLS_CHK(o_link_clock_out, (k < 4))
            @(posedge i_core_clk);
            #1;
            `DLS_CHK(o_serial_lane, first)
            `DLS_CHK(o_link_clock_out, (k < 4))
            @(posedge i_core_clk);
            #1;
        end
        // Words lost before lock are skipped, but order must hold
        while (sent_q.size() > 0 && found == 1'b0) found = (sent_q.pop_front() === w);
        `DLS_CHK(found, 1'b1)
        `DLS_CHK({o_serial_lane_oe_n, o_link_clock_out_oe_n}, 5'h00)
        n_frames++;
    endtask : check_frame

    task automatic run_phase;
        int cnt;
        cnt = 0;
        while (o_lanes_valid !== 1'b1 && cnt < 200) begin
            @(posedge i_core_clk);
            cnt++;
        end
        // Lanes lag the valid flag by one cycle
        repeat (2) @(posedge i_core_clk);
        mon_on = 1'b1;
        n_frames = 0;
        repeat (420) @(posedge i_core_clk);
        `DLS_CHK(n_frames >= 28, 1'b1)
    endtask : run_phase

    task automatic shut_down;
        @(posedge o_link_clock_out);
        mon_on = 1'b0;
        @(negedge i_core_clk);
        i_shutdown_n = 1'b0;
        repeat (3) @(posedge i_core_clk);
        #1;
        `DLS_CHK({o_serial_lane_oe_n, o_link_clock_out_oe_n}, 5'h1F)
        @(posedge i_core_clk);
        #1;
        `DLS_CHK({o_serial_lane, o_link_clock_out, o_lanes_valid, o_overflow}, 7'h00)
    endtask : shut_down

    task automatic wake;
        int cnt;
        cnt = 0;
        @(negedge i_core_clk);
        i_shutdown_n = 1'b1;
        while (o_lanes_valid !== 1'b1 && cnt < 200) begin
            @(posedge i_core_clk);
            #1;
            cnt++;
        end
        `DLS_CHK(cnt >= LOCK_SIM && cnt <= LOCK_SIM + 6, 1'b1)
    endtask : wake

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_core_clk) begin
        cyc++;
        if (sent === 1'b1) sent_q.push_back(sent_word);
        if (cyc == 3000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        forever begin
            @(posedge i_core_clk);
            #1;
            if (o_lanes_valid === 1'b0) `DLS_CHK(o_serial_lane, 4'h0)
            while (mon_on && o_lanes_valid === 1'b1 && o_link_clock_out === 1'b1 && !lprev)
                check_frame();
            lprev = o_link_clock_out;
        end
    end

    initial begin
        repeat (16) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_nrst = 1'b1;
        run_phase();
        shut_down();
        repeat (10) @(negedge i_core_clk);
        i_capture_edge_select = 1'b0;
        repeat (20) @(negedge i_core_clk);
        wake();
        run_phase();
        `DLS_CHK(o_overflow, 1'b0)
        complete_run();
    end
endmodule : dls_serializer_tb_top

// >>> tb/dls_src_model.sv
// Purpose: Pixel source model, drives pixel clock and parallel words
// Assumes: Paced by core clock falling edge
// Notes: Junk word between captures exposes a wrong capture edge

`timescale 1ns/10ps

module dls_src_model #(
    parameter int PERIOD_CYC = 14
) (
    input wire logic i_core_clk,
    input wire logic i_edge_sel,
    output logic o_pixel_clock,
    output logic [27:0] o_data,
    output logic o_sent,
    output logic [27:0] o_sent_word
);
    int cnt = 0;
    integer seed = 9;

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        o_pixel_clock = 1'b0;
        o_data = 28'h0000000;
        o_sent = 1'b0;
        o_sent_word = 28'h0000000;
    end

    // Period scaled up so the core clock can sample it; no modulation at all
    always @(negedge i_core_clk) begin
        cnt = (cnt == PERIOD_CYC - 1) ? 0 : cnt + 1;
        // Half duty; selected edge always falls at count zero
        o_pixel_clock = ((cnt < PERIOD_CYC / 2) == i_edge_sel);
        o_sent = 1'b0;
        if (cnt == PERIOD_CYC - 4) begin
            o_data = 28'($random(seed));
            o_sent_word = o_data;
            o_sent = 1'b1;
        end
        if (cnt == 3) begin
            o_data = ~o_data;
        end
    end
endmodule : dls_src_model
